// File: hw/serial_mem_pkg.sv
// Constants, types and carriers of the serial memory command controller
// Behaviour
// - Abandon an operation with no memory answer within 30 ms, back to idle.
// - Time-out sets sticky command bit 9; only a host write clears it.
// - Pin pulled high with no memory: commands finish, never time out.
// - With the pin pulled high, busy clears once the sequence is shifted out.
// - Only erase, erase-all, write, write-all poll for ready and time out.
// - Read-only bit 8 shows a valid memory gave the station address cleanly.
// - Bit 8 sets after a successful power-up load and after a successful reload.
// - Command bits 7:0 hold the byte address, host writable, reset zero.
// - Data bits 7:0 hold last byte read or next to write; rest reserved.
package serial_mem_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFF_CMD      = 8'hB0;
	localparam logic [7:0]  OFF_DATA     = 8'hB4;
	localparam logic [7:0]  OFF_IRQ_STAT = 8'hB8;
	localparam logic [7:0]  OFF_IRQ_MASK = 8'hBC;

	localparam int          CMD_BUSY_BIT   = 31;
	localparam int          CMD_OP_LSB     = 28;
	localparam int          CMD_TO_BIT     = 9;
	localparam int          CMD_LOADED_BIT = 8;
	localparam int          IRQ_DONE_BIT   = 0;
	localparam int          IRQ_TO_BIT     = 1;

	localparam logic [7:0]  RST_ADDR = 8'h00;
	localparam logic [7:0]  RST_DATA = 8'h00;
	localparam logic [1:0]  RST_MASK = 2'h0;

	// ----------------------------------------------------------------
	// Commands and serial framing
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ   = 3'h0,
		OP_EWDS   = 3'h1,
		OP_WR_EN     = 3'h2,
		OP_WRITE     = 3'h3,
		OP_WR_ALL    = 3'h4,
		OP_ERASE     = 3'h5,
		OP_ERASE_ALL = 3'h6,
		OP_RELOAD = 3'h7
	} op_e;

	localparam logic [1:0]  OPC_READ   = 2'h2;
	localparam logic [1:0]  OPC_WRITE  = 2'h1;
	localparam logic [1:0]  OPC_ERASE  = 2'h3;
	localparam logic [1:0]  OPC_EXT    = 2'h0;
	localparam logic [7:0]  EXT_EWDS   = 8'h00;
	localparam logic [7:0]  EXT_WR_ALL    = 8'h40;
	localparam logic [7:0]  EXT_ERASE_ALL = 8'h80;
	localparam logic [7:0]  EXT_WR_EN     = 8'hC0;
	localparam logic [4:0]  FRAME_LONG  = 5'd19;
	localparam logic [4:0]  FRAME_SHORT = 5'd11;
	localparam logic [4:0]  DATA_BITS   = 5'd8;

	localparam logic [2:0]  RELOAD_LAST = 3'h6;
	localparam logic [7:0]  RELOAD_SIG  = 8'hA5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ         = 25;
	localparam int          SK_HALF_NS      = 500;
	localparam int          SK_HALF_CYC     = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int          TIMEOUT_MS      = 30;
	localparam int          TIMEOUT_CYC_DEF = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int          TMR_W           = 20;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic cs;
		logic sk;
		logic data_out;
		logic data_oe;
	} mem_pins_s;

endpackage : serial_mem_pkg

// File: hw/serial_mem_ctrl.sv
// Serial memory command controller with APB registers
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module serial_mem_ctrl #(
	parameter int unsigned TIMEOUT_CYCLES = serial_mem_pkg::TIMEOUT_CYC_DEF
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire serial_mem_pkg::apb_req_s apb_req,
	output serial_mem_pkg::apb_rsp_s  apb_rsp,
	input  wire logic                 serial_mem_data_pin_in,
	output serial_mem_pkg::mem_pins_s mem_pins,
	output logic [47:0]               station_addr,
	output logic                      irq
);
	import serial_mem_pkg::*;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_OUT  = 6'b000010,
		ST_IN   = 6'b000100,
		ST_GAP  = 6'b001000,
		ST_POLL = 6'b010000,
		ST_END  = 6'b100000
	} st_e;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]       div_reg;
	logic             tick;
	logic             din_s1_reg;
	logic             din_s2_reg;
	logic             busy_reg;
	op_e              op_reg;
	logic [7:0]       addr_reg;
	logic [7:0]       data_reg;
	logic             to_reg;
	logic             loaded_reg;
	logic [1:0]       stat_reg;
	logic [1:0]       mask_reg;
	logic             rl_active_reg;
	logic [2:0]       rl_idx_reg;
	logic [39:0]      stage_reg;
	st_e              st_reg;
	logic             phase_reg;
	logic [4:0]       bit_cnt_reg;
	logic [18:0]      shift_reg;
	logic [7:0]       in_reg;
	logic [TMR_W-1:0] tmr_reg;
	logic             rd_flag_reg;
	logic             ev_done_reg;
	logic             ev_to_reg;
	logic             access;
	logic             hit;
	logic             wr_done;
	logic             wr_cmd;
	logic             wr_data;
	logic             wr_stat;
	logic             wr_mask;
	logic [31:0]      rd_mux;
	op_e              eff_op;
	logic [7:0]       eff_addr;
	logic             sig_bad;

	// ----------------------------------------------------------------
	// Serial clock divider and pin synchroniser
	// ----------------------------------------------------------------
	assign tick = (div_reg == 8'(SK_HALF_CYC - 1));

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 8'h00;
		end else if (tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			din_s1_reg <= 1'b0;
			din_s2_reg <= 1'b0;
		end else begin
			din_s1_reg <= serial_mem_data_pin_in;
			din_s2_reg <= din_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Frame building
	// ----------------------------------------------------------------
	assign eff_op   = rl_active_reg ? OP_READ : op_reg;
	assign eff_addr = rl_active_reg ? {5'h00, rl_idx_reg} : addr_reg;

	function automatic logic [18:0] frame(input op_e op, input logic [7:0] a,
			input logic [7:0] d);
		logic [18:0] f;
		f = 19'h00000;
		unique case (op)
			OP_READ:   f = {1'b1, OPC_READ, a, d};
			OP_EWDS:   f = {1'b1, OPC_EXT, EXT_EWDS, d};
			OP_WR_EN:     f = {1'b1, OPC_EXT, EXT_WR_EN, d};
			OP_WRITE:     f = {1'b1, OPC_WRITE, a, d};
			OP_WR_ALL:    f = {1'b1, OPC_EXT, EXT_WR_ALL, d};
			OP_ERASE:     f = {1'b1, OPC_ERASE, a, d};
			OP_ERASE_ALL: f = {1'b1, OPC_EXT, EXT_ERASE_ALL, d};
			OP_RELOAD: f = {1'b1, OPC_READ, a, d};
		endcase
		return f;
	endfunction : frame

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_reg      <= ST_IDLE;
			phase_reg   <= 1'b0;
			bit_cnt_reg <= 5'h00;
			shift_reg   <= 19'h00000;
			in_reg      <= 8'h00;
			tmr_reg     <= '0;
			rd_flag_reg <= 1'b0;
			ev_done_reg <= 1'b0;
			ev_to_reg   <= 1'b0;
			mem_pins    <= '0;
		end else begin
			ev_done_reg <= 1'b0;
			ev_to_reg   <= 1'b0;
			unique case (st_reg)
				ST_IDLE: begin
					mem_pins.data_oe <= 1'b0;
					// Busy still reads high the cycle after a time-out
					if (busy_reg && tick && !ev_to_reg) begin
						shift_reg <= frame(eff_op, eff_addr, data_reg);
						mem_pins.data_out <= 1'b1;
						mem_pins.data_oe  <= 1'b1;
						mem_pins.cs       <= 1'b1;
						mem_pins.sk       <= 1'b0;
						phase_reg         <= 1'b0;
						rd_flag_reg       <= (eff_op == OP_READ);
						if (eff_op == OP_WRITE || eff_op == OP_WR_ALL) begin
							bit_cnt_reg <= FRAME_LONG - 5'd1;
						end else begin
							bit_cnt_reg <= FRAME_SHORT - 5'd1;
						end
						st_reg <= ST_OUT;
					end
				end
				ST_OUT: begin
					if (tick && !phase_reg) begin
						mem_pins.sk <= 1'b1;
						phase_reg   <= 1'b1;
					end else if (tick) begin
						mem_pins.sk <= 1'b0;
						phase_reg   <= 1'b0;
						if (bit_cnt_reg == 5'h00) begin
							mem_pins.data_oe <= 1'b0;
							if (rd_flag_reg) begin
								bit_cnt_reg <= DATA_BITS - 5'd1;
								st_reg      <= ST_IN;
							end else if (op_reg == OP_WRITE
									|| op_reg == OP_WR_ALL
									|| op_reg == OP_ERASE
									|| op_reg == OP_ERASE_ALL) begin
								mem_pins.cs <= 1'b0;
								st_reg      <= ST_GAP;
							end else begin
								mem_pins.cs <= 1'b0;
								st_reg      <= ST_END;
							end
						end else begin
							shift_reg         <= {shift_reg[17:0], 1'b0};
							mem_pins.data_out <= shift_reg[17];
							bit_cnt_reg       <= bit_cnt_reg - 5'd1;
						end
					end
				end
				ST_IN: begin
					if (tick && !phase_reg) begin
						mem_pins.sk <= 1'b1;
						phase_reg   <= 1'b1;
						in_reg      <= {in_reg[6:0], din_s2_reg};
					end else if (tick) begin
						mem_pins.sk <= 1'b0;
						phase_reg   <= 1'b0;
						if (bit_cnt_reg == 5'h00) begin
							mem_pins.cs <= 1'b0;
							st_reg      <= ST_END;
						end else begin
							bit_cnt_reg <= bit_cnt_reg - 5'd1;
						end
					end
				end
				ST_GAP: begin
					if (tick) begin
						mem_pins.cs <= 1'b1;
						tmr_reg     <= '0;
						st_reg      <= ST_POLL;
					end
				end
				ST_POLL: begin
					if (din_s2_reg) begin
						mem_pins.cs <= 1'b0;
						st_reg      <= ST_END;
					end else if (tmr_reg == TMR_W'(TIMEOUT_CYCLES - 1)) begin
						mem_pins.cs <= 1'b0;
						ev_to_reg   <= 1'b1;
						st_reg      <= ST_IDLE;
					end else begin
						tmr_reg <= tmr_reg + TMR_W'(1);
					end
				end
				ST_END: begin
					if (tick) begin
						ev_done_reg <= 1'b1;
						st_reg      <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command sequencing and station address load
	// ----------------------------------------------------------------
	// Reset starts the automatic load, so no strap is sampled
	assign sig_bad = (rl_idx_reg == 3'h0) && (in_reg != RELOAD_SIG);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy_reg      <= 1'b1;
			op_reg        <= OP_RELOAD;
			rl_active_reg <= 1'b1;
			rl_idx_reg    <= 3'h0;
			addr_reg      <= RST_ADDR;
		end else if (ev_to_reg) begin
			busy_reg      <= 1'b0;
			rl_active_reg <= 1'b0;
		end else if (ev_done_reg) begin
			if (rl_active_reg && !sig_bad && rl_idx_reg != RELOAD_LAST) begin
				rl_idx_reg <= rl_idx_reg + 3'h1;
			end else begin
				busy_reg      <= 1'b0;
				rl_active_reg <= 1'b0;
			end
		end else if (wr_cmd && !busy_reg) begin
			addr_reg <= apb_req.pwdata[7:0];
			if (apb_req.pwdata[CMD_BUSY_BIT]) begin
				busy_reg      <= 1'b1;
				op_reg        <= op_e'(apb_req.pwdata[CMD_OP_LSB +: 3]);
				rl_active_reg <= (op_e'(apb_req.pwdata[CMD_OP_LSB +: 3])
					== OP_RELOAD);
				rl_idx_reg    <= 3'h0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loaded_reg   <= 1'b0;
			stage_reg    <= 40'h0000000000;
			station_addr <= 48'h000000000000;
		end else if (ev_done_reg && rl_active_reg) begin
			if (rl_idx_reg == RELOAD_LAST) begin
				loaded_reg   <= 1'b1;
				station_addr <= {in_reg, stage_reg};
			end else if (rl_idx_reg != 3'h0) begin
				stage_reg[8*(rl_idx_reg-3'h1) +: 8] <= in_reg;
			end
		end else if (ev_to_reg || (wr_cmd && !busy_reg
				&& apb_req.pwdata[CMD_BUSY_BIT]
				&& op_e'(apb_req.pwdata[CMD_OP_LSB +: 3]) == OP_RELOAD)) begin
			// only a clean load keeps it set
			loaded_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			data_reg <= RST_DATA;
		end else if (ev_done_reg && rd_flag_reg && !rl_active_reg) begin
			data_reg <= in_reg;
		end else if (wr_data && !busy_reg) begin
			data_reg <= apb_req.pwdata[7:0];
		end
	end

	// Set wins over the host clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			to_reg <= 1'b0;
		end else if (ev_to_reg) begin
			to_reg <= 1'b1;
		end else if (wr_cmd && apb_req.pwdata[CMD_TO_BIT]) begin
			to_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, mask and output
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stat_reg <= 2'h0;
		end else begin
			stat_reg[IRQ_DONE_BIT] <= ev_done_reg
				| (stat_reg[IRQ_DONE_BIT]
				& ~(wr_stat & apb_req.pwdata[IRQ_DONE_BIT]));
			stat_reg[IRQ_TO_BIT] <= ev_to_reg
				| (stat_reg[IRQ_TO_BIT]
				& ~(wr_stat & apb_req.pwdata[IRQ_TO_BIT]));
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mask_reg <= RST_MASK;
		end else if (wr_mask) begin
			mask_reg <= apb_req.pwdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// One wait state keeps read data and error straight from flops
	assign access  = apb_req.psel && apb_req.penable && !apb_rsp.pready;
	assign wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready
		&& apb_req.pwrite;
	assign wr_cmd  = wr_done && (apb_req.paddr == OFF_CMD);
	assign wr_data = wr_done && (apb_req.paddr == OFF_DATA);
	assign wr_stat = wr_done && (apb_req.paddr == OFF_IRQ_STAT);
	assign wr_mask = wr_done && (apb_req.paddr == OFF_IRQ_MASK);

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h00000000;
		unique case (apb_req.paddr)
			OFF_CMD:      rd_mux = {busy_reg, op_reg, 18'h00000, to_reg,
				loaded_reg, addr_reg};
			OFF_DATA:     rd_mux = {24'h000000, data_reg};
			OFF_IRQ_STAT: rd_mux = {30'h00000000, stat_reg};
			OFF_IRQ_MASK: rd_mux = {30'h00000000, mask_reg};
			default:      hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= access;
			apb_rsp.pslverr <= access && !hit;
			if (access && !apb_req.pwrite) begin
				apb_rsp.prdata <= rd_mux;
			end else if (access) begin
				apb_rsp.prdata <= 32'h00000000;
			end
		end
	end

endmodule : serial_mem_ctrl

// File: verif/serial_mem_ctrl_props.sv
// Port checks for the serial memory controller
`timescale 1ns/1ns
module serial_mem_ctrl_props #(
	parameter int unsigned TIMEOUT_CYCLES = 200
) (
	input wire logic                      clk_sys,
	input wire logic                      nrst,
	input wire serial_mem_pkg::apb_req_s  apb_req,
	input wire serial_mem_pkg::apb_rsp_s  apb_rsp,
	input wire logic                      serial_mem_data_pin_in,
	input wire serial_mem_pkg::mem_pins_s mem_pins,
	input wire logic [47:0]               station_addr,
	input wire logic                      irq
);
	import serial_mem_pkg::*;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic        acc;
	logic        hit;
	logic [31:0] cs_cnt;
	assign acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
	assign hit = apb_req.paddr inside {OFF_CMD, OFF_DATA, OFF_IRQ_STAT,
		OFF_IRQ_MASK};
	// Frame length plus poll window; a longer chip select means a hang
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) cs_cnt <= '0;
		else cs_cnt <= mem_pins.cs ? cs_cnt + 32'h1 : '0;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ready_after_access: assert property (
		acc |=> apb_rsp.pready) else $error("Ready missing");
	a_ready_one_pulse: assert property (
		apb_rsp.pready |=> !apb_rsp.pready) else $error("Ready held");
	a_error_on_unmapped: assert property (
		acc |=> apb_rsp.pslverr != $past(hit)) else $error("Bad error");
	a_unmapped_reads_zero: assert property (
		acc && !hit |=> apb_rsp.prdata == 32'h0) else $error("Bad data");
	a_data_upper_zero: assert property (
		acc && !apb_req.pwrite && apb_req.paddr == OFF_DATA
		|=> apb_rsp.prdata[31:8] == 24'h0) else $error("Upper set");
	a_select_bounded: assert property (
		cs_cnt < TIMEOUT_CYCLES + 4000) else $error("Select hung");
	a_clock_half_wide: assert property (
		$rose(mem_pins.sk) |-> mem_pins.sk[*8]) else $error("Short sk");
	a_drive_in_frame: assert property (
		mem_pins.data_oe |-> mem_pins.cs) else $error("Stray drive");
	c_error: cover property (apb_rsp.pslverr);
	c_irq: cover property ($rose(irq));
	c_frame: cover property ($rose(mem_pins.cs));
endmodule : serial_mem_ctrl_props
bind serial_mem_ctrl serial_mem_ctrl_props #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props (.clk_sys(clk_sys),
	.nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.serial_mem_data_pin_in(serial_mem_data_pin_in), .mem_pins(mem_pins),
	.station_addr(station_addr), .irq(irq));

// File: verif/serial_mem_model.sv
// Serial memory: pulled low, pulled high, or present with pull-up
`timescale 1ns/1ns
module serial_mem_model (
	input wire logic       clk_sys,
	input wire logic       cs,
	input wire logic       sk,
	input wire logic       pin,
	input wire logic [1:0] mode,
	output logic           dout
);
	logic [7:0]  mem [256];
	logic [17:0] sh;
	logic [7:0]  rdb;
	logic        sk_q, rd, rbit, we;
	int          cnt, bsy;
	initial begin
		we = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = (i < 7) ? 8'(8'h11 * i) : 8'hFF;
		mem[0] = 8'hA5;
	end
	always @(posedge clk_sys) begin
		sk_q <= sk;
		if (bsy > 0) bsy <= bsy - 1;
		if (!cs) begin
			cnt <= 0;
			rd <= 1'b0;
		end else if (sk && !sk_q && mode == 2'd2) begin
			cnt <= cnt + 1;
			sh <= {sh[16:0], pin};
			// Read byte shifts out MSB first
			if (rd) begin
				rbit <= rdb[7];
				rdb <= rdb << 1;
			end
			if (cnt == 10) begin
				case (sh[8:7])
					2'h2: begin
						rd <= 1'b1;
						rbit <= mem[{sh[6:0], pin}][7];
						rdb <= mem[{sh[6:0], pin}] << 1;
					end
					2'h3: if (we) begin
						mem[{sh[6:0], pin}] <= 8'hFF;
						bsy <= 60;
					end
					2'h0: if (sh[6:5] == 2'h3) we <= 1'b1;
						else if (sh[6:5] == 2'h0) we <= 1'b0;
						else if (sh[6:5] == 2'h2 && we) begin
							for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
							bsy <= 60;
						end
					default: ;
				endcase
			end
			if (cnt == 18 && we && sh[16:15] == 2'h1) begin
				mem[sh[14:7]] <= {sh[6:0], pin};
				bsy <= 60;
			end
			if (cnt == 18 && we && sh[16:13] == 4'h1) begin
				for (int i = 0; i < 256; i++) mem[i] <= {sh[6:0], pin};
				bsy <= 60;
			end
		end
	end
	// Busy answers low while selected; released line reads the pull level
	assign dout = (mode == 2'd0) ? 1'b0 : (mode == 2'd1) ? 1'b1 :
		rd ? rbit : !(cs && bsy > 0);
endmodule : serial_mem_model

// File: verif/tb.sv
// Self-checking bench for the serial memory controller
`timescale 1ns/1ns
module tb;
	import serial_mem_pkg::*;
	logic        clk_sys, nrst, pin, irq, mdo;
	logic [1:0]  mode;
	apb_req_s    req;
	apb_rsp_s    rsp;
	mem_pins_s   mp;
	logic [47:0] station;
	logic [65:0] notes[$];
	logic [31:0] rd;
	logic [7:0]  a, d;
	int          errors, samples_checked;
	serial_mem_ctrl #(.TIMEOUT_CYCLES(200)) uut (.clk_sys(clk_sys),
		.nrst(nrst), .apb_req(req), .apb_rsp(rsp),
		.serial_mem_data_pin_in(pin), .mem_pins(mp),
		.station_addr(station), .irq(irq));
	serial_mem_model mem (.clk_sys(clk_sys), .cs(mp.cs), .sk(mp.sk),
		.pin(pin), .mode(mode), .dout(mdo));
	assign pin = mp.data_oe ? mp.data_out : mdo;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// Bus tasks; each transfer leaves a note for the monitor
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, input logic [32:0] m, input logic [32:0] e);
		int n;
		@(posedge clk_sys);
		req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:ad, pwdata:wd};
		notes.push_back({m, e & m});
		@(posedge clk_sys);
		req.penable <= 1'b1;
		n = 0;
		do @(posedge clk_sys); while (rsp.pready !== 1'b1 && ++n < 20);
		if (n >= 20) errors++;
		rd = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		xfer(1'b1, ad, wd, 33'h100000000, 33'h0);
	endtask : wr
	task automatic idle();
		int n;
		n = 0;
		// Poll busy before the next command
		do xfer(1'b0, OFF_CMD, 32'h0, 33'h0, 33'h0);
		while (rd[CMD_BUSY_BIT] !== 1'b0 && ++n < 1500);
		check(64'(n < 1500), 64'h1);
	endtask : idle
	task automatic run(input logic [2:0] op, input logic [7:0] ad);
		wr(OFF_CMD, {1'b1, op, 20'h0, ad});
		idle();
	endtask : run
	always @(posedge clk_sys) begin
		logic [65:0] nt;
		if (req.psel && req.penable && rsp.pready === 1'b1) begin
			nt = notes.pop_front();
			if (nt[65:33] != 33'h0) check(64'({rsp.pslverr, rsp.prdata}
				& nt[65:33]), 64'(nt[32:0]));
		end
	end
	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#2000000;
		errors++;
		finish_test();
	end
	initial begin
		void'($urandom(52));
		nrst = 1'b0;
		mode = 2'd2;
		req = '0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		idle();
		check(64'(station), 64'h665544332211);
		xfer(1'b0, OFF_CMD, 0, 33'h3FF, 33'h100);
		xfer(1'b0, OFF_DATA, 0, '1, 33'h0);
		xfer(1'b0, OFF_IRQ_MASK, 0, '1, 33'h0);
		xfer(1'b0, 8'hC4, 0, '1, 33'h100000000);
		d = 8'($urandom);
		wr(OFF_DATA, {24'($urandom), d});
		xfer(1'b0, OFF_DATA, 0, '1, {25'h0, d});
		// Power-up load leaves done set; clear it so irq means this command
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_IRQ_MASK, 32'h1);
		run(3'h2, 8'h00);
		check(64'(irq), 64'h1);
		wr(OFF_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(64'(irq), 64'h0);
		wr(OFF_IRQ_MASK, 32'h0);
		// Stay clear of the locations the reload reads back
		a = 8'($urandom) | 8'h08;
		wr(OFF_DATA, {24'h0, d});
		run(OP_WRITE, a);
		wr(OFF_DATA, 32'h0);
		run(OP_READ, a);
		xfer(1'b0, OFF_DATA, 0, 33'hFF, {25'h0, d});
		xfer(1'b0, OFF_CMD, 0, 33'h2FF, {25'h0, a});
		mode <= 2'd0;
		for (int op = 0; op < 8; op++) begin
			run(3'(op), 8'h00);
			xfer(1'b0, OFF_CMD, 0, 33'h200,
				{23'h0, (op inside {[3:6]}), 9'h0});
			wr(OFF_CMD, 32'h200);
			// Loaded holds until the first time-out clears it
			xfer(1'b0, OFF_CMD, 0, 33'h300,
				{23'h0, 1'b0, (op < 3), 8'h0});
		end
		mode <= 2'd1;
		for (int op = 0; op < 8; op++) begin
			run(3'(op), a);
			xfer(1'b0, OFF_CMD, 0, 33'h200, 33'h0);
		end
		run(OP_READ, a);
		xfer(1'b0, OFF_DATA, 0, 33'hFF, 33'hFF);
		mode <= 2'd2;
		run(OP_RELOAD, 8'h00);
		xfer(1'b0, OFF_CMD, 0, 33'h300, 33'h100);
		finish_test();
	end
endmodule : tb
